// ---- rf_cmd_pkg.sv ----
`default_nettype none
package rf_cmd_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ        = 125;
  localparam int DWELL_UNIT_US  = 500;
  localparam int DWELL_UNIT_CYC = DWELL_UNIT_US * CLK_MHZ;

  // ==========================================================================
  // Widths and depths
  localparam int FREQ_W     = 40;
  localparam int LIST_DEPTH = 64;
  localparam int LIST_AW    = 6;

  // ==========================================================================
  // Bus register byte offsets
  localparam logic [7:0] OFS_CMD_ADDR = 8'h00;
  localparam logic [7:0] OFS_WORD_LO  = 8'h04;
  localparam logic [7:0] OFS_WORD_HI  = 8'h08;
  localparam logic [7:0] OFS_GO       = 8'h0C;
  localparam logic [7:0] OFS_RES_LO   = 8'h10;
  localparam logic [7:0] OFS_RES_HI   = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam int         GO_WRITE_BIT = 0;
  localparam int         GO_READ_BIT  = 1;

  // ==========================================================================
  // Command register addresses
  localparam logic [7:0] CMD_INIT       = 8'h01;
  localparam logic [7:0] CMD_FREQ       = 8'h02;
  localparam logic [7:0] CMD_PHASE      = 8'h03;
  localparam logic [7:0] CMD_SYNTH      = 8'h04;
  localparam logic [7:0] CMD_TONE_SWEEP = 8'h05;
  localparam logic [7:0] CMD_LIST_CFG   = 8'h06;
  localparam logic [7:0] CMD_START      = 8'h07;
  localparam logic [7:0] CMD_STOP       = 8'h08;
  localparam logic [7:0] CMD_STEP       = 8'h09;
  localparam logic [7:0] CMD_DWELL      = 8'h0A;
  localparam logic [7:0] CMD_CYCLES     = 8'h0B;
  localparam logic [7:0] CMD_POINTS     = 8'h0C;
  localparam logic [7:0] CMD_BUF_WRITE  = 8'h0D;
  localparam logic [7:0] CMD_BUF_XFER   = 8'h0E;
  localparam logic [7:0] CMD_SOFT_TRIG  = 8'h0F;
  localparam logic [7:0] CMD_LEVEL      = 8'h10;
  localparam logic [7:0] CMD_OUT_EN     = 8'h11;
  localparam logic [7:0] CMD_AUTO_LVL   = 8'h12;
  localparam logic [7:0] CMD_LVL_LOOP   = 8'h13;
  localparam logic [7:0] CMD_BUF_READ   = 8'h14;

  // ==========================================================================
  // Field positions and markers
  localparam int SYN_SPUR_OFF_BIT  = 0;
  localparam int SYN_LOW_GAIN_BIT  = 1;
  localparam int SYN_FRAC_BIT      = 2;
  localparam int LST_SOFT_TRIG_BIT = 0;
  localparam int LST_USE_BUF_BIT   = 1;
  localparam logic [FREQ_W-1:0] LIST_END_MARK = 40'h0F_FFFF_FFFF;
  localparam logic [FREQ_W-1:0] FREQ_DEFAULT  = 40'h00_3B9A_CA00;
  localparam logic [31:0]       DWELL_DEFAULT = 32'h0000_0001;

  // ==========================================================================
  // Configuration image
  typedef struct packed {
    logic [FREQ_W-1:0] freq;
    logic [31:0]       phase;
    logic              spur_off;
    logic              low_gain;
    logic              frac_sel;
    logic              sweep_sel;
    logic [7:0]        list_cfg;
    logic [FREQ_W-1:0] start;
    logic [FREQ_W-1:0] stop;
    logic [FREQ_W-1:0] step;
    logic [31:0]       dwell;
    logic [31:0]       cycles;
    logic [15:0]       points;
    logic [15:0]       level;
    logic              out_en;
    logic              auto_off;
    logic              open_loop;
  } cfg_t;

  localparam cfg_t CFG_DEFAULT = '{freq: FREQ_DEFAULT, dwell: DWELL_DEFAULT, default: '0};

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_ARM   = 3'b010,
    SEQ_DWELL = 3'b100
  } seq_state_t;

endpackage
`default_nettype wire

// ---- list_if.sv ----
`default_nettype none
interface list_if
  import rf_cmd_pkg::*;
  ;
  logic               wr_en;
  logic [LIST_AW-1:0] wr_idx;
  logic [FREQ_W-1:0]  wr_data;
  logic [LIST_AW-1:0] rd_idx;
  logic [FREQ_W-1:0]  rd_data;
  logic               copy_start;
  logic               copy_to_nv;
  logic               copy_busy;

  modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, copy_start, copy_to_nv, input rd_data, copy_busy);
  modport mem  (input wr_en, wr_idx, wr_data, rd_idx, copy_start, copy_to_nv, output rd_data, copy_busy);
endinterface
`default_nettype wire

// ---- list_buffer.sv ----
`default_nettype none
module list_buffer
  import rf_cmd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  // Controller side
  list_if.mem       lb
);

  typedef struct packed {
    logic               busy;
    logic               to_nv;
    logic [LIST_AW-1:0] idx;
  } copy_t;

  copy_t             st;
  copy_t             next_st;
  logic [FREQ_W-1:0] ram [LIST_DEPTH];
  logic [FREQ_W-1:0] nv  [LIST_DEPTH];

  // ==========================================================================
  // Copy engine, one entry per cycle
  always_comb
  begin
    next_st = st;
    if (!st.busy && lb.copy_start)
    begin
      next_st.busy  = 1'b1;
      next_st.to_nv = lb.copy_to_nv;
      next_st.idx   = '0;
    end
    else if (st.busy)
    begin
      next_st.idx  = st.idx + 1'b1;
      next_st.busy = (st.idx != LIST_AW'(LIST_DEPTH - 1));
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st <= '0;
    else if (i_ce)
      st <= next_st;
  end

  // Storage; a copy into the RAM owns the RAM write port while busy
  always_ff @(posedge i_clk)
  begin
    if (i_ce && st.busy && st.to_nv)
      nv[st.idx] <= ram[st.idx];
    if (i_ce && st.busy && !st.to_nv)
      ram[st.idx] <= nv[st.idx];
    else if (i_ce && lb.wr_en)
      ram[lb.wr_idx] <= lb.wr_data;
  end

  assign lb.rd_data   = ram[lb.rd_idx];
  assign lb.copy_busy = st.busy;

endmodule
`default_nettype wire

// ---- dwell_timer.sv ----
`default_nettype none
module dwell_timer
  import rf_cmd_pkg::*;
#(
  parameter int UNIT_CYCLES = DWELL_UNIT_CYC
)
(
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // Control
  input  wire logic        i_load,
  input  wire logic        i_cancel,
  input  wire logic [31:0] i_units,
  // Result
  output logic             o_expire
);

  typedef struct packed {
    logic        active;
    logic [31:0] units_left;
    logic [31:0] cyc;
    logic        expire;
  } dwell_t;

  dwell_t st;
  dwell_t next_st;

  // ==========================================================================
  // Unit prescaler and unit count; zero units is treated as one
  always_comb
  begin
    next_st        = st;
    next_st.expire = 1'b0;
    if (i_cancel)
      next_st.active = 1'b0;
    else if (i_load)
    begin
      next_st.active     = 1'b1;
      next_st.cyc        = '0;
      next_st.units_left = (i_units == '0) ? 32'h0000_0001 : i_units;
    end
    else if (st.active)
    begin
      next_st.cyc = st.cyc + 32'h0000_0001;
      if (st.cyc == 32'(UNIT_CYCLES - 1))
      begin
        next_st.cyc        = '0;
        next_st.units_left = st.units_left - 32'h0000_0001;
        if (st.units_left == 32'h0000_0001)
        begin
          next_st.active = 1'b0;
          next_st.expire = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st <= '0;
    else if (i_ce)
      st <= next_st;
  end

  assign o_expire = st.expire;

endmodule
`default_nettype wire

// ---- rf_source_command_interface.sv ----
`default_nettype none
module rf_source_command_interface
  import rf_cmd_pkg::*;
#(
  parameter int DWELL_CYCLES = DWELL_UNIT_CYC
)
(
  // Clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  // Avalon-MM slave
  input  wire logic [7:0]        i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [31:0]       i_writedata,
  input  wire logic [3:0]        i_byteenable,
  output logic      [31:0]       o_readdata,
  output logic                   o_waitrequest,
  // Synthesizer status and trigger
  input  wire logic              i_spur_hazard,
  input  wire logic              i_hw_trigger,
  // Primary channel controls
  output logic      [FREQ_W-1:0] o_freq,
  output logic      [31:0]       o_phase,
  output logic      [15:0]       o_level,
  output logic                   o_output_en,
  output logic                   o_auto_level_off,
  output logic                   o_level_open_loop,
  output logic                   o_spur_avoid_off,
  output logic                   o_low_gain,
  output logic                   o_offset_frac,
  output logic                   o_sweep_mode,
  output logic                   o_sweep_active,
  output logic                   o_level_update,
  output logic                   o_dev_reset
);

  // ==========================================================================
  // State
  typedef struct packed {
    cfg_t              cfg;
    logic [7:0]        cmd_addr;
    logic [63:0]       word;
    logic [63:0]       result;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [LIST_AW:0]  wr_ptr;
    logic              loading;
    seq_state_t        seq;
    logic              done;
    logic [15:0]       idx;
    logic [31:0]       cyc_done;
    logic [FREQ_W-1:0] cur;
    logic [FREQ_W-1:0] out_freq;
    logic              offset_frac;
    logic              level_upd;
    logic              dev_reset;
  } state_t;

  localparam state_t ST_RESET = '{cfg: CFG_DEFAULT, waitreq: 1'b1, seq: SEQ_IDLE, out_freq: FREQ_DEFAULT,
                                  default: '0};

  state_t            st;
  state_t            next_st;
  logic              rst_meta;
  logic              rst_n;
  logic              dw_load;
  logic              dw_cancel;
  logic              dw_expire;
  logic              go_wr;
  logic              go_rd;
  logic              soft_go;
  logic              use_buf;
  logic              last_pt;
  logic [FREQ_W-1:0] first_freq;
  logic [FREQ_W-1:0] w_freq;
  logic [31:0]       rd_mux;
  list_if            lb ();

  // ==========================================================================
  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else if (i_ce)
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // Submodules
  list_buffer u_list (
    .i_clk  (i_clk),
    .i_rstn (rst_n),
    .i_ce   (i_ce),
    .lb     (lb.mem)
  );

  dwell_timer #(.UNIT_CYCLES(DWELL_CYCLES)) u_dwell (
    .i_clk    (i_clk),
    .i_rstn   (rst_n),
    .i_ce     (i_ce),
    .i_load   (dw_load),
    .i_cancel (dw_cancel),
    .i_units  (st.cfg.dwell),
    .o_expire (dw_expire)
  );

  // Byte-lane merge for bus writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  // ==========================================================================
  // Shared decode terms
  always_comb
  begin
    use_buf    = st.cfg.list_cfg[LST_USE_BUF_BIT];
    w_freq     = st.word[FREQ_W-1:0];
    first_freq = use_buf ? lb.rd_data : st.cfg.start;
    if (use_buf)
      last_pt = (st.idx + 16'h0001) >= st.cfg.points;
    else
      last_pt = (st.cur + st.cfg.step) > st.cfg.stop;
    go_wr   = !st.waitreq && i_write && (i_address == OFS_GO) && i_byteenable[0] && i_writedata[GO_WRITE_BIT];
    go_rd   = !st.waitreq && i_write && (i_address == OFS_GO) && i_byteenable[0] && i_writedata[GO_READ_BIT];
    // Only the controller's own arm state can accept a trigger
    soft_go = go_wr && (st.cmd_addr == CMD_SOFT_TRIG) && st.cfg.sweep_sel
              && st.cfg.list_cfg[LST_SOFT_TRIG_BIT] && (st.seq == SEQ_ARM);
  end

  // Bus read mux, unmapped offsets read zero
  always_comb
  begin
    if (i_address == OFS_CMD_ADDR)
      rd_mux = {24'h00_0000, st.cmd_addr};
    else if (i_address == OFS_WORD_LO)
      rd_mux = st.word[31:0];
    else if (i_address == OFS_WORD_HI)
      rd_mux = st.word[63:32];
    else if (i_address == OFS_RES_LO)
      rd_mux = st.result[31:0];
    else if (i_address == OFS_RES_HI)
      rd_mux = st.result[63:32];
    else if (i_address == OFS_STATUS)
      rd_mux = {st.idx, 10'h000, st.loading, st.done, st.seq, lb.copy_busy};
    else
      rd_mux = 32'h0000_0000;
  end

  // ==========================================================================
  // Next state: bus, sequencer, command execution
  always_comb
  begin
    next_st           = st;
    next_st.waitreq   = 1'b1;
    next_st.level_upd = 1'b0;
    next_st.dev_reset = 1'b0;
    dw_load           = 1'b0;
    dw_cancel         = 1'b0;
    lb.wr_en          = 1'b0;
    lb.wr_idx         = st.wr_ptr[LIST_AW-1:0];
    lb.wr_data        = w_freq;
    lb.copy_start     = 1'b0;
    lb.copy_to_nv     = st.word[0];
    lb.rd_idx         = (st.seq == SEQ_DWELL && !last_pt) ? LIST_AW'(st.idx + 16'h0001) : '0;

    // Accept one request per hand-shake; copy in progress holds the bus off
    if (st.waitreq && (i_read || i_write) && !lb.copy_busy)
    begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = rd_mux;
    end
    if (!st.waitreq && i_write)
    begin
      if (i_address == OFS_CMD_ADDR)
        next_st.cmd_addr = 8'(be_merge({24'h00_0000, st.cmd_addr}, i_writedata, i_byteenable));
      else if (i_address == OFS_WORD_LO)
        next_st.word[31:0] = be_merge(st.word[31:0], i_writedata, i_byteenable);
      else if (i_address == OFS_WORD_HI)
        next_st.word[63:32] = be_merge(st.word[63:32], i_writedata, i_byteenable);
    end

    // List / sweep sequencer
    case (st.seq)
      SEQ_IDLE:
      begin
        if (st.cfg.sweep_sel && !st.done)
          next_st.seq = SEQ_ARM;
      end
      SEQ_ARM:
      begin
        if (st.cfg.list_cfg[LST_SOFT_TRIG_BIT] ? soft_go : i_hw_trigger)
        begin
          next_st.idx      = '0;
          next_st.cyc_done = '0;
          next_st.cur      = first_freq;
          next_st.seq      = SEQ_DWELL;
          dw_load          = 1'b1;
        end
      end
      SEQ_DWELL:
      begin
        if (dw_expire && last_pt)
        begin
          next_st.cyc_done = st.cyc_done + 32'h0000_0001;
          // Zero count never matches, so the sweep repeats forever
          if (st.cfg.cycles != '0 && next_st.cyc_done >= st.cfg.cycles)
          begin
            next_st.seq  = SEQ_IDLE;
            next_st.done = 1'b1;
          end
          else
          begin
            next_st.idx = '0;
            next_st.cur = first_freq;
            dw_load     = 1'b1;
          end
        end
        else if (dw_expire)
        begin
          next_st.idx = st.idx + 16'h0001;
          next_st.cur = use_buf ? lb.rd_data : st.cur + st.cfg.step;
          dw_load     = 1'b1;
        end
      end
      default:
        next_st.seq = SEQ_IDLE;
    endcase
    if (!st.cfg.sweep_sel)
    begin
      next_st.seq  = SEQ_IDLE;
      next_st.done = 1'b0;
      dw_cancel    = 1'b1;
    end

    // Write command: store the word in the addressed register; CMD_INIT, CMD_BUF_WRITE and CMD_BUF_XFER act on it instead
    if (go_wr)
    begin
      if (st.cmd_addr == CMD_INIT)
      begin
        next_st.seq       = SEQ_IDLE;
        next_st.done      = 1'b0;
        next_st.loading   = 1'b0;
        next_st.dev_reset = 1'b1;
        dw_cancel         = 1'b1;
        if (st.word[0])
          next_st.cfg = CFG_DEFAULT;
      end
      else if (st.cmd_addr == CMD_FREQ)
        next_st.cfg.freq = w_freq;
      else if (st.cmd_addr == CMD_PHASE)
        next_st.cfg.phase = st.word[31:0];
      else if (st.cmd_addr == CMD_SYNTH)
      begin
        next_st.cfg.spur_off = st.word[SYN_SPUR_OFF_BIT];
        next_st.cfg.low_gain = st.word[SYN_LOW_GAIN_BIT];
        next_st.cfg.frac_sel = st.word[SYN_FRAC_BIT];
      end
      else if (st.cmd_addr == CMD_TONE_SWEEP)
        next_st.cfg.sweep_sel = st.word[0];
      else if (st.cmd_addr == CMD_LIST_CFG)
        next_st.cfg.list_cfg = st.word[7:0];
      else if (st.cmd_addr == CMD_START)
        next_st.cfg.start = w_freq;
      else if (st.cmd_addr == CMD_STOP)
        next_st.cfg.stop = w_freq;
      else if (st.cmd_addr == CMD_STEP)
        next_st.cfg.step = w_freq;
      else if (st.cmd_addr == CMD_DWELL)
        next_st.cfg.dwell = st.word[31:0];
      else if (st.cmd_addr == CMD_CYCLES)
        next_st.cfg.cycles = st.word[31:0];
      else if (st.cmd_addr == CMD_POINTS)
        next_st.cfg.points = st.word[15:0];
      else if (st.cmd_addr == CMD_BUF_WRITE)
      begin
        if (w_freq == '0)
        begin
          next_st.wr_ptr  = '0;
          next_st.loading = 1'b1;
        end
        else if (w_freq == LIST_END_MARK)
        begin
          next_st.cfg.points = 16'(st.wr_ptr);
          next_st.loading    = 1'b0;
        end
        else if (st.wr_ptr < (LIST_AW + 1)'(LIST_DEPTH))
        begin
          // Entries past the end are dropped rather than wrapped
          lb.wr_en       = 1'b1;
          next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
      end
      else if (st.cmd_addr == CMD_BUF_XFER)
        lb.copy_start = 1'b1;
      else if (st.cmd_addr == CMD_LEVEL)
        next_st.cfg.level = st.word[15:0];
      else if (st.cmd_addr == CMD_OUT_EN)
        next_st.cfg.out_en = st.word[0];
      else if (st.cmd_addr == CMD_AUTO_LVL)
        next_st.cfg.auto_off = st.word[0];
      else if (st.cmd_addr == CMD_LVL_LOOP)
        next_st.cfg.open_loop = st.word[0];
    end

    // Read command: the command address selects what comes back
    if (go_rd)
    begin
      if (st.cmd_addr == CMD_FREQ)
        next_st.result = 64'(st.out_freq);
      else if (st.cmd_addr == CMD_PHASE)
        next_st.result = 64'(st.cfg.phase);
      else if (st.cmd_addr == CMD_SYNTH)
        next_st.result = {61'h0, st.cfg.frac_sel, st.cfg.low_gain, st.cfg.spur_off};
      else if (st.cmd_addr == CMD_LEVEL)
        next_st.result = 64'(st.cfg.level);
      else if (st.cmd_addr == CMD_POINTS)
        next_st.result = 64'(st.cfg.points);
      else if (st.cmd_addr == CMD_BUF_READ)
      begin
        // Shares the read port; overrides the sequencer's index in any state, dwell included
        lb.rd_idx      = st.word[LIST_AW-1:0];
        next_st.result = 64'(lb.rd_data);
      end
      else
        next_st.result = {56'h0, st.seq, st.done, st.loading, lb.copy_busy, st.cfg.sweep_sel, st.cfg.out_en};
    end

    // Outputs derived from the new configuration
    next_st.out_freq    = (next_st.seq == SEQ_DWELL) ? next_st.cur : next_st.cfg.freq;
    next_st.offset_frac = next_st.cfg.frac_sel || (!next_st.cfg.spur_off && i_spur_hazard);
    // Leveling follows every frequency change unless switched off
    next_st.level_upd   = (next_st.out_freq != st.out_freq) && !next_st.cfg.auto_off;
  end

  // ==========================================================================
  // State register, frozen while the enable is low
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= ST_RESET;
    else if (i_ce)
      st <= next_st;
  end

  // Outputs
  assign o_readdata        = st.rdata;
  assign o_waitrequest     = st.waitreq;
  assign o_freq            = st.out_freq;
  assign o_phase           = st.cfg.phase;
  assign o_level           = st.cfg.level;
  assign o_output_en       = st.cfg.out_en;
  assign o_auto_level_off  = st.cfg.auto_off;
  assign o_level_open_loop = st.cfg.open_loop;
  assign o_spur_avoid_off  = st.cfg.spur_off;
  assign o_low_gain        = st.cfg.low_gain;
  assign o_offset_frac     = st.offset_frac;
  assign o_sweep_mode      = st.cfg.sweep_sel;
  assign o_sweep_active    = st.seq[2]; // One-hot dwell bit, no gate
  assign o_level_update    = st.level_upd;
  assign o_dev_reset       = st.dev_reset;

endmodule
`default_nettype wire

// ---- rf_cmd_monitor.sv ----
`default_nettype none
module rf_cmd_monitor
  import rf_cmd_pkg::*;
#(
  parameter int DWELL_CYCLES = DWELL_UNIT_CYC
)
(
  // Clock, reset, bus
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic        i_spur_hazard,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  // Channel controls
  input wire logic        o_auto_level_off,
  input wire logic        o_spur_avoid_off,
  input wire logic        o_offset_frac,
  input wire logic        o_sweep_mode,
  input wire logic        o_sweep_active,
  input wire logic        o_level_update,
  input wire logic        o_dev_reset
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================================
  // Handshake, copy stall bounded by 70 cycles
  AST_ACK_ONE: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property (!o_waitrequest |-> (i_read || i_write))
    else $error("ack without request");
  AST_ACK_BOUND: assert property ($rose(i_read || i_write) |-> ##[1:70] !o_waitrequest)
    else $error("request not answered");
  AST_RDATA_HOLD: assert property (o_waitrequest |-> $stable(o_readdata))
    else $error("read data moved outside ack");
  // Control side effects
  AST_RESET_PULSE: assert property (o_dev_reset |=> !o_dev_reset)
    else $error("device reset pulse too long");
  AST_SPUR_SWITCH: assert property ($past(i_spur_hazard) && !o_spur_avoid_off |-> o_offset_frac)
    else $error("no fractional switch on spur hazard");
  AST_NO_LEVEL: assert property (o_auto_level_off && $past(o_auto_level_off) |-> !o_level_update)
    else $error("leveling while disabled");
  AST_SWEEP_MODE: assert property (o_sweep_active |-> $past(o_sweep_mode))
    else $error("sweep active in tone mode");
  cover property (o_dev_reset);
  cover property (o_sweep_active);
  cover property (o_level_update);
endmodule
bind rf_source_command_interface rf_cmd_monitor #(.DWELL_CYCLES(DWELL_CYCLES)) mon (.*);
`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
module host_model
(
  // Clock and answer
  input  wire logic        i_clk,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  // Request
  output logic      [7:0]  o_address,
  output logic             o_read,
  output logic             o_write,
  output logic      [31:0] o_writedata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Idle bus at time zero
  initial
  begin
    o_address = 8'h00;
    o_read = 1'h0;
    o_write = 1'h0;
    o_writedata = 32'h0;
  end
  // One transfer, held until waitrequest is seen low; a spare edge avoids re-raising in one step
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    o_address <= a;
    o_read <= rd;
    o_write <= !rd;
    o_writedata <= d;
    do
      @(posedge i_clk);
    while (i_waitrequest);
    q = i_readdata;
    o_read <= 1'h0;
    o_write <= 1'h0;
    @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top
  import rf_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 4;
  logic              i_clk, i_rstn, i_ce, i_read, i_write, i_spur_hazard, i_hw_trigger, o_waitrequest;
  logic [7:0]        i_address;
  logic [3:0]        i_byteenable;
  logic [31:0]       i_writedata, o_readdata, o_phase, q;
  logic [FREQ_W-1:0] o_freq;
  logic [15:0]       o_level;
  logic              o_output_en, o_auto_level_off, o_level_open_loop, o_spur_avoid_off, o_low_gain;
  logic              o_offset_frac, o_sweep_mode, o_sweep_active, o_level_update, o_dev_reset;
  logic [63:0]       r;
  int                miscompares, check_count;
  int                resets, ups;
  rf_source_command_interface #(.DWELL_CYCLES(DW)) dut (.*);
  host_model hm (.i_clk(i_clk), .i_waitrequest(o_waitrequest), .i_readdata(o_readdata), .o_address(i_address),
                 .o_read(i_read), .o_write(i_write), .o_writedata(i_writedata));
  // Count one-cycle pulses; unknowns before reset are not counted
  always @(posedge i_clk)
  begin
    resets <= resets + int'(o_dev_reset === 1'b1);
    ups    <= ups + int'(o_level_update === 1'b1);
  end
  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    end_sim();
  end
  task automatic end_sim();
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] s);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Command: address, word halves, then execute
  task automatic cmd(input logic [7:0] a, input logic [63:0] w, input logic [1:0] go = 2'h1);
    hm.xfer(0, OFS_CMD_ADDR, {24'h0, a}, q);
    hm.xfer(0, OFS_WORD_LO, w[31:0], q);
    hm.xfer(0, OFS_WORD_HI, w[63:32], q);
    hm.xfer(0, OFS_GO, {30'h0, go}, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [63:0] w, input logic [63:0] e);
    cmd(a, w, 2'h2);
    hm.xfer(1, OFS_RES_LO, 32'h0, r[31:0]);
    hm.xfer(1, OFS_RES_HI, 32'h0, r[63:32]);
    cmp("result", e, r);
  endtask
  // Main sequence
  initial
  begin
    {i_rstn, i_spur_hazard, i_hw_trigger, i_ce, i_byteenable} = 8'h1F;
    i_rstn = 0;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1;
    repeat (3) @(posedge i_clk);
    cmp("freq", FREQ_DEFAULT, o_freq);
    hm.xfer(1, 8'hF0, 32'h0, q);
    cmp("unmapped", 0, q);
    cmd(CMD_LEVEL, 64'hFFFF_0000_0000_00C8);
    cmp("level", 16'h00C8, o_level);
    cmd(CMD_PHASE, 64'h1234_5678);
    cmp("phase", 32'h1234_5678, o_phase);
    cmd(CMD_OUT_EN, 1);
    cmd(CMD_AUTO_LVL, 1);
    cmd(CMD_LVL_LOOP, 1);
    cmp("flags", 3'h7, {o_output_en, o_auto_level_off, o_level_open_loop});
    for (int i = 0; i < 8; i++)
    begin
      cmd(CMD_SYNTH, i);
      cmp("synth", i[2:0], {o_offset_frac, o_low_gain, o_spur_avoid_off});
    end
    i_spur_hazard <= 1;
    cmd(CMD_SYNTH, 0);
    cmp("spur", 1, o_offset_frac);
    cmd(CMD_SYNTH, 1);
    cmp("nospur", 0, o_offset_frac);
    i_spur_hazard <= 0;
    cmd(CMD_AUTO_LVL, 0);
    cmd(CMD_FREQ, 64'h12_3456_789A);
    rdc(CMD_FREQ, 0, 64'h12_3456_789A);
    cmd(CMD_INIT, 0);
    cmp("keep", 16'h00C8, o_level);
    cmd(CMD_INIT, 1);
    cmp("dflt", {16'h0, FREQ_DEFAULT}, {o_level, o_freq});
    // List load: zero rewinds, marker closes; points stay within what is loaded
    cmd(CMD_BUF_WRITE, 0);
    for (int i = 1; i < 4; i++)
      cmd(CMD_BUF_WRITE, i * 1000);
    cmd(CMD_BUF_WRITE, LIST_END_MARK);
    rdc(CMD_POINTS, 0, 3);
    rdc(CMD_BUF_READ, 1, 2000);
    cmd(CMD_BUF_XFER, 1);
    cmd(CMD_BUF_WRITE, 0);
    cmd(CMD_BUF_WRITE, 7);
    cmd(CMD_BUF_XFER, 0);
    rdc(CMD_BUF_READ, 0, 1000);
    // Arithmetic sweep, three points, one cycle
    cmd(CMD_START, 100);
    cmd(CMD_STOP, 300);
    cmd(CMD_STEP, 100);
    cmd(CMD_CYCLES, 1);
    cmd(CMD_LIST_CFG, 1);
    cmd(CMD_SOFT_TRIG, 0);
    cmp("idle", 0, o_sweep_active);
    cmd(CMD_TONE_SWEEP, 1);
    cmd(CMD_SOFT_TRIG, 0);
    for (int n = 0; n < 50 && o_sweep_active !== 1; n++)
      @(posedge i_clk);
    cmp("start", 41'h100_0000_0064, {o_sweep_mode, o_freq});
    repeat (40) @(posedge i_clk);
    cmp("stop", 0, o_sweep_active);
    cmp("resets", 2, resets);
    // Six frequency changes: set, restore, three points, back to tone
    cmp("levels", 6, ups);
    // Buffered sweep on the hardware trigger; entry 0 came back by the copy
    cmd(CMD_TONE_SWEEP, 0);
    cmd(CMD_LIST_CFG, 2);
    i_hw_trigger <= 1;
    cmd(CMD_TONE_SWEEP, 1);
    for (int n = 0; n < 50 && o_sweep_active !== 1; n++)
      @(posedge i_clk);
    cmp("hwlist", 41'h100_0000_03E8, {o_sweep_active, o_freq});
    end_sim();
  end
endmodule
`default_nettype wire
